//--- rtl/host_port_consts.vh
`ifndef HOST_PORT_CONSTS_VH
`define HOST_PORT_CONSTS_VH
// Bus widths.
`define HP_ADDR_W        6
`define HP_DATA_W        8
// Number of addressable register words behind the port.
`define HP_NUM_REGS      64
// Interrupt vector register location in the local register file.
`define HP_IVR_ADDR      6'h3c
// Threshold register location.
`define HP_THRESH_ADDR   6'h3d
// Source enable register location.
`define HP_ENABLE_ADDR   6'h3e
// Current interrupt register location, read only.
`define HP_CIR_ADDR      6'h3f
// Reset values.
`define HP_IVR_RST       8'h00
`define HP_THRESH_RST    8'h00
`define HP_ENABLE_RST    8'h00
`define HP_CIR_RST       8'h00
// Wait countdown load; acknowledge comes this many cycles plus one after the strobe is seen.
`define HP_ACK_DELAY     2'h1
`endif

//--- rtl/host_bus_interrupt_port.v
// What this block does
// - An access is requested only while chip select is low with read or write strobe.
// - The six-bit address chooses the register read or written.
// - The eight-bit data bus is driven only for read data or vector.
// - Read strobe with chip select drives the addressed register onto the bus.
// - Write strobe with chip select stores bus data into the addressed register.
// - Data acknowledge, open-drain and active low, follows every access.
// - On reads, acknowledge comes only once valid data is on the bus.
// - On writes, acknowledge comes only after data has been captured.
// - Interrupt request goes low when an enabled source level exceeds the threshold.
// - Interrupt acknowledge returns the vector, possibly modified, with data acknowledge.
// - Each interrupt acknowledge updates the current interrupt register.
// - Master reset releases request and acknowledge and clears vector, enable and current interrupt registers, not the threshold.
`timescale 1ns/1ns
`include "host_port_consts.vh"
module host_bus_interrupt_port (
  input  wire       mclk_i,
  input  wire       arst_n_i,
  input  wire       master_reset_i,
  input  wire       chip_select_n_i,
  input  wire       read_strobe_n_i,
  input  wire       write_strobe_n_i,
  input  wire       interrupt_acknowledge_n_i,
  input  wire [5:0] register_address_i,
  input  wire [7:0] host_data_bus_i,
  output reg  [7:0] host_data_bus_o,
  output wire       host_data_bus_oe_o,
  output wire       data_acknowledge_n_o,
  output wire       data_acknowledge_n_oe_o,
  output wire       interrupt_request_n_o,
  output wire       interrupt_request_n_oe_o,
  input  wire [3:0] channel_source_valid_i,
  input  wire [7:0] channel_source_level_i,
  input  wire [1:0] channel_source_id_i,
  output wire [7:0] current_interrupt_o
);

  // Cycle states.
  localparam [1:0] ST_IDLE = 2'b00;
  localparam [1:0] ST_WAIT = 2'b01;
  localparam [1:0] ST_ACK  = 2'b10;
  localparam [1:0] ST_DONE = 2'b11;

  // Kinds of cycle.
  localparam [1:0] K_RD  = 2'b00;
  localparam [1:0] K_WR  = 2'b01;
  localparam [1:0] K_IAK = 2'b10;

  // Three-stage synchronisers for the host strobes; index 0 is the first stage.
  reg  [2:0] cs_s_q;
  reg  [2:0] rd_s_q;
  reg  [2:0] wr_s_q;
  reg  [2:0] iak_s_q;
  reg        cs_n_q;
  reg        rd_n_q;
  reg        wr_n_q;
  reg        iak_n_q;

  reg  [1:0] state_q;
  reg  [1:0] kind_q;
  reg  [1:0] dly_q;
  reg        drive_q;
  reg  [5:0] addr_q;
  reg  [7:0] regs_q [0:`HP_NUM_REGS-1];
  reg  [7:0] ivr_q;
  reg  [7:0] thresh_q;
  reg  [7:0] enable_q;
  reg  [7:0] cir_q;
  reg        irq_q;

  wire       req_rd;
  wire       req_wr;
  wire       req_iak;
  wire       hit_any;
  wire       start_active;
  wire [7:0] vector_mod;

  // A level only counts once stages two and three agree, so a glitch cannot start a cycle.
  always @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cs_s_q  <= 3'h7;
      rd_s_q  <= 3'h7;
      wr_s_q  <= 3'h7;
      iak_s_q <= 3'h7;
      cs_n_q  <= 1'b1;
      rd_n_q  <= 1'b1;
      wr_n_q  <= 1'b1;
      iak_n_q <= 1'b1;
    end else begin
      cs_s_q  <= {cs_s_q[1:0], chip_select_n_i};
      rd_s_q  <= {rd_s_q[1:0], read_strobe_n_i};
      wr_s_q  <= {wr_s_q[1:0], write_strobe_n_i};
      iak_s_q <= {iak_s_q[1:0], interrupt_acknowledge_n_i};
      if (cs_s_q[1] == cs_s_q[2]) cs_n_q <= cs_s_q[2];
      if (rd_s_q[1] == rd_s_q[2]) rd_n_q <= rd_s_q[2];
      if (wr_s_q[1] == wr_s_q[2]) wr_n_q <= wr_s_q[2];
      if (iak_s_q[1] == iak_s_q[2]) iak_n_q <= iak_s_q[2];
    end
  end

  // Register accesses need chip select; the acknowledge cycle relies on it being high.
  assign req_rd  = !cs_n_q && !rd_n_q;
  assign req_wr  = !cs_n_q && !wr_n_q && rd_n_q;
  assign req_iak = cs_n_q && !iak_n_q;

  // Whichever request opened the cycle must be released before the next one starts.
  assign start_active = (kind_q == K_RD)  ? req_rd :
                        (kind_q == K_WR)  ? req_wr : req_iak;

  // Vector is modified by the serviced channel number in its low two bits.
  assign vector_mod = {ivr_q[7:2], channel_source_id_i};

  // Interrupt raised by any enabled source above the programmed threshold.
  assign hit_any = |(channel_source_valid_i & enable_q[3:0]) &&
                   (channel_source_level_i > thresh_q);

  // Reads pick the named registers first, the general file otherwise.
  function [7:0] read_mux;
    input [5:0] a;
    begin
      case (a)
        `HP_IVR_ADDR:    read_mux = ivr_q;
        `HP_THRESH_ADDR: read_mux = thresh_q;
        `HP_ENABLE_ADDR: read_mux = enable_q;
        `HP_CIR_ADDR:    read_mux = cir_q;
        default:         read_mux = regs_q[a];
      endcase
    end
  endfunction

  // Cycle controller: capture, wait two cycles, acknowledge, then hold until release.
  always @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_q         <= ST_IDLE;
      kind_q          <= K_RD;
      dly_q           <= 2'h0;
      drive_q         <= 1'b0;
      addr_q          <= 6'h00;
      host_data_bus_o <= 8'h00;
      ivr_q           <= `HP_IVR_RST;
      thresh_q        <= `HP_THRESH_RST;
      enable_q        <= `HP_ENABLE_RST;
      cir_q           <= `HP_CIR_RST;
    end else if (master_reset_i) begin
      state_q         <= ST_IDLE;
      drive_q         <= 1'b0;
      ivr_q           <= `HP_IVR_RST;
      enable_q        <= `HP_ENABLE_RST;
      cir_q           <= `HP_CIR_RST;
    end else begin
      case (state_q)
        ST_IDLE: begin
          dly_q <= `HP_ACK_DELAY;
          if (req_iak) begin
            kind_q          <= K_IAK;
            host_data_bus_o <= vector_mod;
            cir_q           <= {channel_source_level_i[5:0], channel_source_id_i};
            drive_q         <= 1'b1;
            state_q         <= ST_WAIT;
          end else if (req_rd) begin
            kind_q          <= K_RD;
            addr_q          <= register_address_i;
            host_data_bus_o <= read_mux(register_address_i);
            drive_q         <= 1'b1;
            state_q         <= ST_WAIT;
          end else if (req_wr) begin
            kind_q  <= K_WR;
            addr_q  <= register_address_i;
            state_q <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          // Address and data are settled by now, so the write lands here.
          if (kind_q == K_WR) begin
            case (addr_q)
              `HP_IVR_ADDR:    ivr_q    <= host_data_bus_i;
              `HP_THRESH_ADDR: thresh_q <= host_data_bus_i;
              `HP_ENABLE_ADDR: enable_q <= host_data_bus_i;
              default:         ;
            endcase
          end
          if (!start_active) begin
            drive_q <= 1'b0;
            state_q <= ST_DONE;
          end else if (dly_q == 2'h0) begin
            state_q <= ST_ACK;
          end else begin
            dly_q <= dly_q - 2'h1;
          end
        end
        ST_ACK: begin
          if (!start_active) begin
            drive_q <= 1'b0;
            state_q <= ST_DONE;
          end
        end
        ST_DONE: begin
          // Wait until no read, write or acknowledge request is active so one access is not taken twice.
          if (!req_rd && !req_wr && !req_iak) state_q <= ST_IDLE;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // General file written by the same capture; the named registers shadow their words.
  always @(posedge mclk_i) begin
    if (state_q == ST_WAIT && kind_q == K_WR && !master_reset_i) begin
      regs_q[addr_q] <= host_data_bus_i;
    end
  end

  // Request line registered so it never glitches on the shared wire.
  always @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      irq_q <= 1'b0;
    end else if (master_reset_i) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= hit_any;
    end
  end

  // Open-drain pins only ever pull low; the enable carries the assertion.
  assign host_data_bus_oe_o       = drive_q;
  assign data_acknowledge_n_o     = 1'b0;
  assign data_acknowledge_n_oe_o  = (state_q == ST_ACK);
  assign interrupt_request_n_o    = 1'b0;
  assign interrupt_request_n_oe_o = irq_q;
  assign current_interrupt_o      = cir_q;

endmodule // host_bus_interrupt_port

//--- dv/host_port_monitor.sv
`timescale 1ns/1ns
module host_port_monitor (
  input wire       mclk_i,
  input wire       arst_n_i,
  input wire       master_reset_i,
  input wire       chip_select_n_i,
  input wire       read_strobe_n_i,
  input wire       write_strobe_n_i,
  input wire       interrupt_acknowledge_n_i,
  input wire [3:0] channel_source_valid_i,
  input wire       host_data_bus_oe_o,
  input wire       data_acknowledge_n_o,
  input wire       data_acknowledge_n_oe_o,
  input wire       interrupt_request_n_o,
  input wire       interrupt_request_n_oe_o,
  input wire [7:0] current_interrupt_o
);
  // Strobes cross a synchroniser, so every bound leaves a few edges of lag.
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!arst_n_i);
  wire idle = read_strobe_n_i & write_strobe_n_i & interrupt_acknowledge_n_i;
  a_pins_open_drain: assert property (!data_acknowledge_n_o && !interrupt_request_n_o)
    else $error("open-drain pin not low");
  // The host lets go as soon as it sees acknowledge, so the opening strobe is one sample back.
  a_ack_needs_request: assert property ($rose(data_acknowledge_n_oe_o) |->
    (!$past(chip_select_n_i) && !$past(read_strobe_n_i & write_strobe_n_i))
    || !$past(interrupt_acknowledge_n_i))
    else $error("ack without a request");
  a_ack_release_idle: assert property (idle [*7] |-> !data_acknowledge_n_oe_o)
    else $error("ack held after release");
  a_drive_only_reads: assert property (
    (read_strobe_n_i & interrupt_acknowledge_n_i) [*7] |-> !host_data_bus_oe_o)
    else $error("bus driven outside read");
  a_access_ack_time: assert property (!chip_select_n_i &&
    $fell(read_strobe_n_i & write_strobe_n_i) |-> ##[3:10] data_acknowledge_n_oe_o)
    else $error("no ack after access");
  a_read_data_first: assert property ($rose(data_acknowledge_n_oe_o) &&
    !$past(read_strobe_n_i) |-> host_data_bus_oe_o)
    else $error("ack before read data");
  a_vector_with_ack: assert property ($rose(data_acknowledge_n_oe_o) &&
    !$past(interrupt_acknowledge_n_i) |-> host_data_bus_oe_o)
    else $error("ack without vector");
  a_master_reset_clears: assert property (master_reset_i |=>
    !interrupt_request_n_oe_o && !data_acknowledge_n_oe_o && current_interrupt_o == 8'h00)
    else $error("master reset left state");
  a_irq_no_source: assert property (
    (channel_source_valid_i == 4'h0) [*3] |-> !interrupt_request_n_oe_o)
    else $error("irq with no source");
endmodule // host_port_monitor
bind host_bus_interrupt_port host_port_monitor i_host_port_monitor (.*);

//--- dv/host_cpu_model.sv
`timescale 1ns/1ns
// Host side: one strobe cycle at a time, held until acknowledge is seen.
module host_cpu_model (
  input  wire       clk_i,
  input  wire       ack_i,
  input  wire [7:0] bus_i,
  output reg        cs_n_o,
  output reg        rd_n_o,
  output reg        wr_n_o,
  output reg        iack_n_o,
  output reg  [5:0] addr_o,
  output reg  [7:0] data_o,
  output reg        hang_o
);
  initial {cs_n_o, rd_n_o, wr_n_o, iack_n_o, addr_o, data_o, hang_o} = {4'hf, 15'h0};
  // Kind 0 reads, 1 writes, 2 acknowledges an interrupt.
  task cycle(input [1:0] k, input [5:0] a, input [7:0] d, output [7:0] q);
    integer n;
    begin
      n = 0;
      @(negedge clk_i);
      addr_o = a;
      data_o = (k == 2'h1) ? d : ~data_o;
      cs_n_o = (k == 2'h2);
      rd_n_o = (k != 2'h0);
      wr_n_o = (k != 2'h1);
      iack_n_o = (k != 2'h2);
      while (!ack_i && n < 30) begin @(negedge clk_i); n = n + 1; end
      if (!ack_i) hang_o = 1'b1;
      q = bus_i;
      {cs_n_o, rd_n_o, wr_n_o, iack_n_o} = 4'hf;
      data_o = ~data_o; // A released line must not keep showing the old byte.
      while (ack_i && n < 60) begin @(negedge clk_i); n = n + 1; end
      if (ack_i) hang_o = 1'b1;
    end
  endtask
endmodule // host_cpu_model

//--- dv/test_host_bus_interrupt_port.sv
`timescale 1ns/1ns
`define CHK(g, e) begin n_tests = n_tests + 1; if ((g) !== (e)) begin n_fail = n_fail + 1; \
  $display("Error at %0t: got %h expected %h", $time, g, e); end end
module test_host_bus_interrupt_port;
  reg         mclk_i, arst_n_i, master_reset_i;
  reg  [3:0]  valid;
  reg  [7:0]  level, q, v, t, mem [0:63];
  reg  [5:0]  a, al [0:15];
  reg  [1:0]  id;
  wire [7:0]  bus_o, hd, current_interrupt_register;
  wire [5:0]  addr;
  wire        cs_n, rd_n, wr_n, iack_n, oe, ack, irq, hang;
  integer     n_fail = 0, n_tests = 0, seed = 32'h1692, i;
  host_bus_interrupt_port i_host_bus_interrupt_port (.mclk_i(mclk_i), .arst_n_i(arst_n_i),
    .master_reset_i(master_reset_i), .chip_select_n_i(cs_n), .read_strobe_n_i(rd_n),
    .write_strobe_n_i(wr_n), .interrupt_acknowledge_n_i(iack_n), .register_address_i(addr),
    .host_data_bus_i(oe ? bus_o : hd), .host_data_bus_o(bus_o), .host_data_bus_oe_o(oe),
    .data_acknowledge_n_o(), .data_acknowledge_n_oe_o(ack), .interrupt_request_n_o(),
    .interrupt_request_n_oe_o(irq), .channel_source_valid_i(valid),
    .channel_source_level_i(level), .channel_source_id_i(id), .current_interrupt_o(current_interrupt_register));
  host_cpu_model i_host_cpu_model (.clk_i(mclk_i), .ack_i(ack), .bus_i(oe ? bus_o : hd),
    .cs_n_o(cs_n), .rd_n_o(rd_n), .wr_n_o(wr_n), .iack_n_o(iack_n), .addr_o(addr),
    .data_o(hd), .hang_o(hang));
  // The vector keeps its top six bits and carries the channel below them.
  function [7:0] vec_exp(input [7:0] r, input [1:0] c); vec_exp = {r[7:2], c}; endfunction
  function [7:0] cir_exp(input [7:0] l, input [1:0] c); cir_exp = {l[5:0], c}; endfunction
  task print_verdict;
    begin
      if (n_fail == 0 && n_tests > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  // A hung handshake ends the run at once.
  task acc(input [1:0] k, input [5:0] ad, input [7:0] d);
    begin
      i_host_cpu_model.cycle(k, ad, d, q);
      `CHK(hang, 1'b0)
      if (hang !== 1'b0) print_verdict;
    end
  endtask
  initial begin
    mclk_i = 1'b0;
    forever #10 mclk_i = ~mclk_i;
  end
  // Storage round trip, read-only slot, thresholds and vector per channel, then master reset once.
  initial begin
    {arst_n_i, master_reset_i, valid, level, id} = 16'h0;
    repeat (6) @(negedge mclk_i);
    arst_n_i = 1'b1;
    for (i = 0; i < 16; i = i + 1) begin
      a = (i == 0) ? 6'h3e : $random(seed);
      if (a == 6'h3f) a = 6'h00;
      al[i] = a;
      mem[a] = $random(seed);
      acc(2'h1, a, mem[a]);
    end
    for (i = 0; i < 16; i = i + 1) begin acc(2'h0, al[i], 8'h00); `CHK(q, mem[al[i]]) end
    acc(2'h1, 6'h3f, 8'ha5);
    acc(2'h0, 6'h3f, 8'h00);
    `CHK(q, 8'h00)
    for (i = 0; i < 4; i = i + 1) begin
      v = $random(seed);
      t = $random(seed) & 8'h7f;
      acc(2'h1, 6'h3c, v);
      acc(2'h1, 6'h3d, t);
      acc(2'h1, 6'h3e, 8'h0f);
      id = i;
      valid = 4'h1 << i;
      level = t;
      repeat (3) @(negedge mclk_i);
      `CHK(irq, 1'b0)
      level = t + 8'h01;
      repeat (3) @(negedge mclk_i);
      `CHK(irq, 1'b1)
      acc(2'h2, 6'h00, 8'h00);
      `CHK(q, vec_exp(v, id))
      `CHK(current_interrupt_register, cir_exp(level, id))
    end
    acc(2'h1, 6'h3e, 8'h00);
    repeat (3) @(negedge mclk_i);
    `CHK(irq, 1'b0)
    acc(2'h1, 6'h3e, 8'h0f);
    master_reset_i = 1'b1;
    @(negedge mclk_i);
    master_reset_i = 1'b0;
    `CHK({irq, current_interrupt_register}, 9'h000)
    acc(2'h0, 6'h3c, 8'h00);
    `CHK(q, 8'h00)
    print_verdict;
  end
endmodule // test_host_bus_interrupt_port
